/* verilog/tsq_pkg.sv */
// tsq_pkg: constants and types of the trigger sequencer step decoder
package tsq_pkg;

   // step command opcodes (4-bit command field)
   localparam logic [3:0] TSQ_OP_WAIT_HIGH = 4'h4;
   localparam logic [3:0] TSQ_OP_WAIT_LOW = 4'h5;
   localparam logic [3:0] TSQ_OP_RAISE_IRQ = 4'h7;
   localparam logic [3:0] TSQ_OP_PULSE_TRIG = 4'h8;

   // option field layout
   localparam int TSQ_OPT_W = 5;
   localparam int TSQ_OPT4_MSB = 3;
   localparam int TSQ_TRIG_N = 32;
   localparam int TSQ_IRQ_N = 4;
   localparam int TSQ_SRC_N = 16;

   // wait source codes
   localparam logic [3:0] TSQ_SRC_PWM_SPECIAL = 4'h0;
   localparam logic [3:0] TSQ_SRC_PWM_SYNC = 4'h1;
   localparam logic [3:0] TSQ_SRC_PWM_GEN1 = 4'h2;
   localparam logic [3:0] TSQ_SRC_PWM_GEN3 = 4'h4;
   localparam logic [3:0] TSQ_SRC_RSVD_A = 4'h5;
   localparam logic [3:0] TSQ_SRC_RSVD_B = 4'h6;
   localparam logic [3:0] TSQ_SRC_OUTPUT_COMPARE_ONE = 4'h7;
   localparam logic [3:0] TSQ_SRC_OUTPUT_COMPARE_TWO = 4'h8;
   localparam logic [3:0] TSQ_SRC_INPUT_CAPTURE_ONE = 4'h9;
   localparam logic [3:0] TSQ_SRC_COMPARATOR_ONE = 4'hA;
   localparam logic [3:0] TSQ_SRC_COMPARATOR_FOUR = 4'hD;
   localparam logic [3:0] TSQ_SRC_ADC_DONE = 4'hE;
   localparam logic [3:0] TSQ_SRC_EXTERNAL_INTERRUPT_TWO = 4'hF;

   // highest valid interrupt option
   localparam logic [3:0] TSQ_IRQ_OPT_MAX = 4'h3;

   // register offsets
   localparam logic [7:0] TSQ_REG_CTRL = 8'h00;
   localparam logic [7:0] TSQ_REG_STATUS = 8'h04;
   localparam logic [7:0] TSQ_REG_MASK = 8'h08;
   localparam logic [7:0] TSQ_REG_STATE = 8'h0C;

   // status / mask bit positions
   localparam int TSQ_EV_DONE = 0;
   localparam int TSQ_EV_NOP = 1;
   localparam int TSQ_EV_IRQ = 2;
   localparam int TSQ_EV_TRIG = 3;
   localparam int TSQ_EV_N = 4;

   // control bit positions
   localparam int TSQ_CTRL_EN = 0;

   // state register field positions
   localparam int TSQ_ST_BUSY = 0;
   localparam int TSQ_ST_POL = 1;
   localparam int TSQ_ST_SEL_LSB = 4;

   // reset values
   localparam logic TSQ_CTRL_EN_RST = 1'b0;
   localparam logic [3:0] TSQ_MASK_RST = 4'h0;

   // step command as carried on the command port
   typedef struct packed {
      logic [3:0] opcode;
      logic [TSQ_OPT_W-1:0] option;
   } tsq_cmd_t;

   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } tsq_bus_t;

   typedef enum logic [1:0] {
      TSQ_IDLE = 2'b01,
      TSQ_WAIT = 2'b10
   } tsq_state_t;

endpackage : tsq_pkg

/* verilog/tsq_wait_select.sv */
// tsq_wait_select: picks the awaited trigger source level for a wait step
`timescale 1ns/1ps
module tsq_wait_select #(
   parameter bit HAS_MC_PWM = 1'b1
) (
   // selection
   input wire logic [3:0] sel,
   input wire logic [tsq_pkg::TSQ_SRC_N-1:0] src_in,
   // result
   output logic level,
   output logic present
);
   import tsq_pkg::*;

   always_comb
   begin
      level = src_in[sel];
      present = 1'b1;
      if (sel == TSQ_SRC_RSVD_A || sel == TSQ_SRC_RSVD_B)
      begin
         present = 1'b0;
      end
      else if (sel <= TSQ_SRC_PWM_GEN3)
      begin
         // pwm sources exist only with the motor-control pwm
         present = HAS_MC_PWM;
      end
      if (!present)
      begin
         level = 1'b0;
      end
   end

endmodule : tsq_wait_select

/* verilog/tsq_step_decode.sv */
// tsq_step_decode: option decoder and executor for trigger sequencer step commands
// How it works
// - wait steps decode option bits 3:0; 0000 awaits the pwm special event.
// - wait option 0001 awaits the pwm master time base sync output.
// - wait option 1110 awaits the analog converter conversion-done interrupt.
// - interrupt step options 0000..0011 raise sequencer interrupts 0..3; rest reserved.
// - reserved commands or options still execute but act as a no-op step.
// - trigger step decodes 5-bit option selecting trigger output 0..31.
// - pwm wait sources 0000..0100 exist only on motor-control pwm variants.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
module tsq_step_decode #(
   parameter bit HAS_MC_PWM = 1'b1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // step command port
   input wire logic cmd_valid,
   input wire tsq_pkg::tsq_cmd_t cmd,
   output logic cmd_ready,
   output logic cmd_done,
   // trigger sources and consumers
   input wire logic [tsq_pkg::TSQ_SRC_N-1:0] src_in,
   output logic [tsq_pkg::TSQ_IRQ_N-1:0] seq_irq,
   output logic [tsq_pkg::TSQ_TRIG_N-1:0] trig_out,
   // register port
   input wire tsq_pkg::tsq_bus_t bus,
   output logic [31:0] rdata,
   // interrupt
   output logic irq
);
   import tsq_pkg::*;

   typedef struct packed {
      tsq_state_t state;
      logic [3:0] wait_sel;
      logic wait_pol;
      logic ready;
      logic done;
      logic [TSQ_IRQ_N-1:0] seq_irq;
      logic [TSQ_TRIG_N-1:0] trig;
      logic ctrl_en;
      logic [TSQ_EV_N-1:0] status;
      logic [TSQ_EV_N-1:0] mask;
      logic [31:0] rdata;
      logic irq;
   } tsq_regs_t;

   tsq_regs_t r;
   tsq_regs_t next_r;

   logic src_level;
   logic src_present;
   logic [TSQ_EV_N-1:0] ev_set;
   logic [TSQ_EV_N-1:0] ev_clr;
   logic [TSQ_EV_N-1:0] next_status;
   logic [TSQ_TRIG_N-1:0] irq_onehot;
   logic [TSQ_TRIG_N-1:0] trig_onehot;
   logic status_nop_q;

   // one-hot decode shared by the interrupt and trigger steps
   function automatic logic [TSQ_TRIG_N-1:0] tsq_onehot(input logic [TSQ_OPT_W-1:0] idx);
      logic [TSQ_TRIG_N-1:0] v;
      v = '0;
      v[idx] = 1'b1;
      return v;
   endfunction : tsq_onehot

   // option bit 4 is ignored by the interrupt step, so it never reaches the decode
   assign irq_onehot = tsq_onehot({1'b0, cmd.option[TSQ_OPT4_MSB:0]});
   assign trig_onehot = tsq_onehot(cmd.option);

   // while waiting, the selector watches the stored wait source, so the option need not stay stable
   tsq_wait_select #(
      .HAS_MC_PWM(HAS_MC_PWM)
   ) u_sel (
      .sel(r.state == TSQ_WAIT ? r.wait_sel : cmd.option[TSQ_OPT4_MSB:0]),
      .src_in(src_in),
      .level(src_level),
      .present(src_present)
   );

   always_comb
   begin
      next_r = r;
      ev_set = '0;
      ev_clr = '0;
      next_r.done = 1'b0;
      next_r.seq_irq = '0;
      next_r.trig = '0;
      next_r.rdata = '0;

      case (r.state)
         TSQ_IDLE:
         begin
            if (cmd_valid && r.ready)
            begin
               if (cmd.opcode == TSQ_OP_WAIT_HIGH || cmd.opcode == TSQ_OP_WAIT_LOW)
               begin
                  if (src_present)
                  begin
                     next_r.state = TSQ_WAIT;
                     next_r.ready = 1'b0;
                     next_r.wait_sel = cmd.option[TSQ_OPT4_MSB:0];
                     next_r.wait_pol = (cmd.opcode == TSQ_OP_WAIT_HIGH);
                  end
                  else
                  begin
                     // absent or reserved source completes at once with no effect
                     next_r.done = 1'b1;
                     ev_set[TSQ_EV_NOP] = 1'b1;
                     ev_set[TSQ_EV_DONE] = 1'b1;
                  end
               end
               else if (cmd.opcode == TSQ_OP_RAISE_IRQ)
               begin
                  next_r.done = 1'b1;
                  ev_set[TSQ_EV_DONE] = 1'b1;
                  if (cmd.option[TSQ_OPT4_MSB:0] <= TSQ_IRQ_OPT_MAX)
                  begin
                     next_r.seq_irq = irq_onehot[TSQ_IRQ_N-1:0];
                     ev_set[TSQ_EV_IRQ] = 1'b1;
                  end
                  else
                  begin
                     ev_set[TSQ_EV_NOP] = 1'b1;
                  end
               end
               else if (cmd.opcode == TSQ_OP_PULSE_TRIG)
               begin
                  next_r.done = 1'b1;
                  next_r.trig = trig_onehot;
                  ev_set[TSQ_EV_TRIG] = 1'b1;
                  ev_set[TSQ_EV_DONE] = 1'b1;
               end
               else
               begin
                  next_r.done = 1'b1;
                  ev_set[TSQ_EV_NOP] = 1'b1;
                  ev_set[TSQ_EV_DONE] = 1'b1;
               end
            end
         end
         TSQ_WAIT:
         begin
            // level-sensitive wait; cleared enable aborts so software can recover
            if (src_level == r.wait_pol || !r.ctrl_en)
            begin
               next_r.state = TSQ_IDLE;
               next_r.ready = r.ctrl_en;
               next_r.done = 1'b1;
               ev_set[TSQ_EV_DONE] = 1'b1;
            end
         end
         default:
         begin
            next_r.state = TSQ_IDLE;
            next_r.ready = 1'b0;
         end
      endcase

      // register writes
      if (bus.wr)
      begin
         if (bus.addr == TSQ_REG_CTRL)
         begin
            next_r.ctrl_en = bus.wdata[TSQ_CTRL_EN];
         end
         else if (bus.addr == TSQ_REG_STATUS)
         begin
            ev_clr = bus.wdata[TSQ_EV_N-1:0];
         end
         else if (bus.addr == TSQ_REG_MASK)
         begin
            next_r.mask = bus.wdata[TSQ_EV_N-1:0];
         end
      end

      if (next_r.state == TSQ_IDLE)
      begin
         next_r.ready = next_r.ctrl_en;
      end

      // a new event wins over a write-one-to-clear in the same cycle
      next_status = (r.status & ~ev_clr) | ev_set;
      next_r.status = next_status;
      next_r.irq = |(next_status & next_r.mask);

      // register reads, data in the following cycle
      if (bus.rd)
      begin
         if (bus.addr == TSQ_REG_CTRL)
         begin
            next_r.rdata[TSQ_CTRL_EN] = r.ctrl_en;
         end
         else if (bus.addr == TSQ_REG_STATUS)
         begin
            next_r.rdata[TSQ_EV_N-1:0] = r.status;
         end
         else if (bus.addr == TSQ_REG_MASK)
         begin
            next_r.rdata[TSQ_EV_N-1:0] = r.mask;
         end
         else if (bus.addr == TSQ_REG_STATE)
         begin
            next_r.rdata[TSQ_ST_BUSY] = (r.state == TSQ_WAIT);
            next_r.rdata[TSQ_ST_POL] = r.wait_pol;
            next_r.rdata[TSQ_ST_SEL_LSB +: 4] = r.wait_sel;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r.state <= TSQ_IDLE;
         r.wait_sel <= 4'h0;
         r.wait_pol <= 1'b0;
         r.ready <= 1'b0;
         r.done <= 1'b0;
         r.seq_irq <= '0;
         r.trig <= '0;
         r.ctrl_en <= TSQ_CTRL_EN_RST;
         r.status <= '0;
         r.mask <= TSQ_MASK_RST;
         r.rdata <= 32'h0000_0000;
         r.irq <= 1'b0;
      end
      else if (clk_en)
      begin
         r <= next_r;
      end
   end

   assign cmd_ready = r.ready;
   assign cmd_done = r.done;
   assign seq_irq = r.seq_irq;
   assign trig_out = r.trig;
   assign rdata = r.rdata;
   assign irq = r.irq;

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   a_trig_onehot: assert property (
      clk_en && cmd_valid && cmd_ready && cmd.opcode == TSQ_OP_PULSE_TRIG
      |=> trig_out == (32'h0000_0001 << $past(cmd.option)) && cmd_done)
      else $error("trigger output does not match option");

   a_irq_valid: assert property (
      clk_en && cmd_valid && cmd_ready && cmd.opcode == TSQ_OP_RAISE_IRQ
      && cmd.option[3:0] <= 4'h3
      |=> seq_irq == (4'h1 << $past(cmd.option[1:0])) && trig_out == '0)
      else $error("sequencer interrupt does not match option");

   a_irq_reserved: assert property (
      clk_en && cmd_valid && cmd_ready && cmd.opcode == TSQ_OP_RAISE_IRQ
      && cmd.option[3:0] > 4'h3
      |=> seq_irq == '0 && cmd_done && status_nop_q)
      else $error("reserved interrupt option had an effect");

   assign status_nop_q = r.status[TSQ_EV_NOP];

   a_rsvd_wait_nop: assert property (
      clk_en && cmd_valid && cmd_ready && cmd.opcode == TSQ_OP_WAIT_HIGH
      && (cmd.option[3:0] == 4'h5 || cmd.option[3:0] == 4'h6)
      |=> cmd_done && cmd_ready)
      else $error("reserved wait option did not complete as no-op");

   a_pwm_variant: assert property (
      clk_en && cmd_valid && cmd_ready && !HAS_MC_PWM
      && cmd.opcode == TSQ_OP_WAIT_LOW && cmd.option[3:0] <= 4'h4
      |=> r.state == TSQ_IDLE && cmd_done)
      else $error("pwm source waited on a variant without pwm");

   a_wait_adc: assert property (
      r.state == TSQ_WAIT && r.wait_sel == 4'hE && clk_en && r.ctrl_en
      && src_in[14] == r.wait_pol
      |=> cmd_done && r.state == TSQ_IDLE)
      else $error("adc done wait did not finish");

   a_wait_holds: assert property (
      r.state == TSQ_WAIT && r.ctrl_en && src_in[r.wait_sel] != r.wait_pol
      |=> r.state == TSQ_WAIT && !cmd_done && !cmd_ready)
      else $error("wait ended before its source matched");

   a_wait_sync: assert property (
      clk_en && cmd_valid && cmd_ready && HAS_MC_PWM
      && cmd.opcode == TSQ_OP_WAIT_HIGH && cmd.option[3:0] == 4'h1
      |=> r.state == TSQ_WAIT && r.wait_sel == 4'h1 && r.wait_pol)
      else $error("sync wait not entered");

   a_unknown_op: assert property (
      clk_en && cmd_valid && cmd_ready && cmd.opcode == 4'h0
      |=> cmd_done && seq_irq == '0 && trig_out == '0
      ##1 (!cmd_done || $past(cmd_valid && cmd_ready) || !$past(clk_en)))
      else $error("unknown opcode had an effect");

   a_irq_level: assert property (
      ##1 irq == $past(|(next_r.status & next_r.mask)) || !$past(clk_en))
      else $error("interrupt level mismatch");

   c_trig_step: cover property (
      clk_en && cmd_valid && cmd_ready && cmd.opcode == TSQ_OP_PULSE_TRIG);
   c_wait_done: cover property (r.state == TSQ_WAIT ##[1:20] cmd_done);
   c_irq_step: cover property (seq_irq != '0);
   c_int_out: cover property (irq);

endmodule : tsq_step_decode

/* bench/tsq_src_model.sv */
// tsq_src_model: trigger source levels as the on-chip peripherals present them
`timescale 1ns/1ps
module tsq_src_model (
   // control from the bench
   input wire logic sys_clk,
   input wire logic arm,
   input wire logic [3:0] sel,
   input wire logic pol,
   input wire logic [3:0] delay,
   // sources
   output logic [tsq_pkg::TSQ_SRC_N-1:0] src_in
);
   import tsq_pkg::*;
   logic [3:0] cnt;
   always_ff @(posedge sys_clk)
   begin
      if (!arm)
         cnt <= delay;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
   end
   // all other sources already show the awaited level, so a wrong pick finishes early
   always_comb
   begin
      src_in = {TSQ_SRC_N{pol}};
      src_in[sel] = (arm && cnt == 4'h0) ? pol : ~pol;
   end
endmodule : tsq_src_model

/* bench/tb_trigger_sequencer_option_decode.sv */
// tb_trigger_sequencer_option_decode: self-checking bench of the step decoder
`timescale 1ns/1ps
module tb_trigger_sequencer_option_decode;
   import tsq_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cmd_valid = 1'b0;
   tsq_cmd_t cmd = '0;
   tsq_bus_t bus = '0;
   logic arm = 1'b0;
   logic [3:0] sel = 4'h0;
   logic pol = 1'b1;
   logic clk_en = 1'b1;
   logic done_np;
   logic cmd_ready, cmd_done, irq;
   logic [TSQ_SRC_N-1:0] src_in;
   logic [TSQ_IRQ_N-1:0] seq_irq;
   logic [TSQ_TRIG_N-1:0] trig_out;
   logic [31:0] rdata;
   int mismatches = 0;
   int num_checks = 0;
   always #5 sys_clk = ~sys_clk;
   tsq_step_decode #(.HAS_MC_PWM(1'b1)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
      .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .cmd_done(cmd_done), .src_in(src_in), .seq_irq(seq_irq), .trig_out(trig_out),
      .bus(bus), .rdata(rdata), .irq(irq));
   // variant without the motor-control pwm, fed the same steps
   tsq_step_decode #(.HAS_MC_PWM(1'b0)) uut_nopwm (.sys_clk(sys_clk), .arst_n(arst_n),
      .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(),
      .cmd_done(done_np), .src_in(src_in), .seq_irq(), .trig_out(), .bus(bus), .rdata(),
      .irq());
   tsq_src_model model (.sys_clk(sys_clk), .arm(arm), .sel(sel), .pol(pol),
      .delay(4'h3), .src_in(src_in));
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus <= '0;
   endtask : reg_wr
   task reg_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus <= '0;
      #1;
      chk(what, exp, rdata);
   endtask : reg_rd
   task step(input logic [3:0] op, input logic [4:0] opt);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd <= '{op, opt};
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      #1;
   endtask : step
   task t_reset;
      chk("ready at reset", 0, cmd_ready);
      reg_rd("ctrl reset", TSQ_REG_CTRL, 0);
      reg_rd("mask reset", TSQ_REG_MASK, 0);
      reg_wr(TSQ_REG_CTRL, 1);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("ready enabled", 1, cmd_ready);
   endtask : t_reset
   task t_trig;
      for (int i = 0; i < 32; i++)
      begin
         step(TSQ_OP_PULSE_TRIG, i[4:0]);
         chk("trig_out", 32'h1 << i, trig_out);
         chk("trig done", 1, cmd_done);
      end
      reg_rd("status trig", TSQ_REG_STATUS, 32'h9);
   endtask : t_trig
   task t_irq_step;
      reg_wr(TSQ_REG_STATUS, 32'hF);
      for (int i = 0; i < 16; i++)
      begin
         step(TSQ_OP_RAISE_IRQ, i[4:0]);
         chk("seq_irq", (i < 4) ? (32'h1 << i) : 0, {28'h0, seq_irq});
         chk("irq step done", 1, cmd_done);
      end
      step(TSQ_OP_RAISE_IRQ, 5'h12);
      chk("seq_irq opt4", 32'h4, {28'h0, seq_irq});
      reg_rd("status irq", TSQ_REG_STATUS, 32'h7);
      reg_wr(TSQ_REG_STATUS, 32'hF);
      step(4'h0, 5'h1F);
      chk("rsvd op done", 1, cmd_done);
      chk("rsvd op pulses", 0, trig_out | {28'h0, seq_irq});
      reg_rd("status rsvd", TSQ_REG_STATUS, 32'h3);
   endtask : t_irq_step
   // each source other than reserved 0101 and 0110 must end the wait exactly when the model raises it, never earlier
   task t_wait(input logic [3:0] op, input logic lvl);
      int n;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge sys_clk);
         sel <= i[3:0];
         pol <= lvl;
         step(op, {1'b0, i[3:0]});
         chk("no pwm wait", (i < 7) ? 1 : 0, done_np);
         if (i == 5 || i == 6)
            chk("rsvd wait done", 1, cmd_done);
         else
         begin
            chk("wait busy", 0, cmd_ready | cmd_done);
            arm <= 1'b1;
            n = 0;
            while (cmd_done !== 1'b1 && n < 20)
            begin
               @(posedge sys_clk);
               #1;
               n++;
            end
            // model delay of 3 plus the edge that sees the awaited level
            chk("wait latency", 4, n);
            arm <= 1'b0;
         end
      end
   endtask : t_wait
   task t_intr;
      step(TSQ_OP_PULSE_TRIG, 5'h0);
      reg_wr(TSQ_REG_MASK, 32'h8);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("irq unmasked", 1, irq);
      reg_wr(TSQ_REG_MASK, 32'h4);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("irq masked", 0, irq);
      reg_wr(TSQ_REG_MASK, 32'h8);
      reg_wr(TSQ_REG_STATUS, 32'h8);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("irq cleared", 0, irq);
      reg_rd("status w1c", TSQ_REG_STATUS, 32'h3);
      reg_rd("unmapped", 8'h10, 0);
   endtask : t_intr
   // a step offered while the clock enable is low must be lost, not delayed
   task t_freeze;
      @(posedge sys_clk);
      clk_en <= 1'b0;
      step(TSQ_OP_PULSE_TRIG, 5'h5);
      chk("frozen step", 0, trig_out | {31'h0, cmd_done});
      @(posedge sys_clk);
      clk_en <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("thawed idle", 0, trig_out | {31'h0, cmd_done});
   endtask : t_freeze
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      end_of_test();
   end
   initial
   begin
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      t_reset();
      t_trig();
      t_irq_step();
      t_wait(TSQ_OP_WAIT_HIGH, 1'b1);
      t_wait(TSQ_OP_WAIT_LOW, 1'b0);
      t_intr();
      t_freeze();
      end_of_test();
   end
endmodule : tb_trigger_sequencer_option_decode
